// ==== verilog/bpd_pkg.sv ====
// ====================================================================
// bridge power/dma configuration package
// ====================================================================
package bpd_pkg;

   // ================================================================
   // register byte offsets
   // ================================================================
   localparam logic [7:0] OFS_SUBSYS_ID   = 8'h40;
   localparam logic [7:0] OFS_LEGACY_BASE = 8'h44;
   localparam logic [7:0] OFS_PM_CAP      = 8'h80;
   localparam logic [7:0] OFS_PM_CSR      = 8'h84;
   localparam logic [7:0] OFS_DMA_SETUP   = 8'h88;
   localparam logic [7:0] OFS_MISC_CTRL   = 8'h98;
   localparam logic [7:0] OFS_HW_STATUS   = 8'h9C;

   // ================================================================
   // field layouts and constant values
   // ================================================================
   localparam logic [1:0]  LEGACY_IO_IND   = 2'h1;
   localparam logic [7:0]  PM_CAP_ID       = 8'h01;
   localparam logic [7:0]  PM_NEXT_PTR     = 8'h00;
   localparam logic [2:0]  PM_REVISION     = 3'h1;
   localparam logic [12:0] PM_CAP_FLAGS    = 13'h1FC2;
   localparam logic [1:0]  DMA_SIZE_8BIT   = 2'h0;
   localparam int          CSR_WAKE_EN_BIT = 8;
   localparam int          CSR_WAKE_ST_BIT = 15;

   // ================================================================
   // reset values
   // ================================================================
   localparam logic [31:0] RST_SUBSYS_ID   = 32'h0000_0000;
   localparam logic [29:0] RST_LEGACY_BASE = 30'h0000_0000;
   localparam logic [1:0]  RST_PWR_STATE   = 2'h0;
   localparam logic [31:0] RST_DMA_SETUP   = 32'h0000_0000;

   // ================================================================
   // axi answers
   // ================================================================
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;

   // socket power states
   typedef enum logic [1:0]
   {
      BPD_D0 = 2'h0,
      BPD_D1 = 2'h1,
      BPD_D2 = 2'h2,
      BPD_D3 = 2'h3
   } bpd_pstate_t;

   // dma configuration seen by the socket logic
   typedef struct packed
   {
      logic        allowed;
      logic        wide16;
      logic        ext_addr;
      logic [27:0] io_base;
   } bpd_dma_cfg_t;

endpackage : bpd_pkg

// ==== verilog/bpd_wake_flag.sv ====
// ====================================================================
// wake status flag and wake pin request
// ====================================================================
module bpd_wake_flag
   import bpd_pkg::*;
(
   // clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // event and control
   input  wire logic wake_event,
   input  wire logic clear_req,
   input  wire logic enable,
   // results
   output logic      status_q,
   output logic      wake_req_q
);

   logic status_d;

   // set wins over a simultaneous clear
   assign status_d = wake_event | (status_q & ~clear_req);

   // sticky status and gated wake request
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         status_q   <= 1'b0;
         wake_req_q <= 1'b0;
      end
      else
      begin
         status_q   <= status_d;
         wake_req_q <= status_d & enable;
      end
   end

   // ================================================================
   // assertions
   // ================================================================
   property p_wake_set;
      @(posedge aclk) disable iff (!aresetn)
      wake_event |=> status_q;
   endproperty
   a_wake_set: assert property (p_wake_set)
      else $error("wake status not set by event");

   property p_wake_clear;
      @(posedge aclk) disable iff (!aresetn)
      (clear_req && !wake_event) |=> !status_q;
   endproperty
   a_wake_clear: assert property (p_wake_clear)
      else $error("wake status not cleared");

endmodule : bpd_wake_flag

// ==== verilog/bpd_config_regs.sv ====
// Contract
// - subsystem id holds vendor id low half, device id high half
// - writes to subsystem id ignored while the lock bit is set
// - legacy base bits 1:0 always read 01
// - legacy base 31:2 writable; window decode off while zero
// - capability byte 0 is read-only power management id
// - next item pointer reads zero
// - power management revision reads 001
// - capability reports wake from all states, aux power, no dsi, no data
// - capability reports D1 and D2 supported
// - no full-speed clock needed for wake; clock-run supported
// - power state field encodes D0 to D3 as 00 to 11
// - wake requests on wake pin only while wake enable set
// - data select and data scale read zero
// - wake status sets on event; write one clears, zero no effect
// - control/status bits 23:16 read zero
// - dma allowed only with channel enable and a request enable
// - transfer size 00 is 8-bit, all else 16-bit
// - extended addressing bit enables extended dma addressing
// - dma setup bits 31:4 hold dma register i/o base
// - lock bit resets to zero and locks subsystem id
module bpd_config_regs
   import bpd_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   // clock and reset
   input  wire logic               aclk,
   input  wire logic               aresetn,
   // axi write address
   input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
   input  wire logic [2:0]         s_axi_awprot,
   input  wire logic               s_axi_awvalid,
   output logic                    s_axi_awready,
   // axi write data
   input  wire logic [31:0]        s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   input  wire logic               s_axi_wvalid,
   output logic                    s_axi_wready,
   // axi write response
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  wire logic               s_axi_bready,
   // axi read address
   input  wire logic [ADDR_W-1:0]  s_axi_araddr,
   input  wire logic [2:0]         s_axi_arprot,
   input  wire logic               s_axi_arvalid,
   output logic                    s_axi_arready,
   // axi read data
   output logic [31:0]             s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  wire logic               s_axi_rready,
   // socket side inputs
   input  wire logic               wake_event,
   input  wire logic [1:0]         dma_request_enable,
   // socket side outputs
   output logic                    wake_pin_req,
   output bpd_pstate_t             power_state,
   output logic                    legacy_decode_en,
   output logic [29:0]             legacy_io_base,
   output bpd_dma_cfg_t            dma_cfg
);

   // ================================================================
   // elaboration checks
   // ================================================================
   if (ADDR_W < 8)
   begin : g_chk
      $error("ADDR_W must be at least 8");
   end

   // ================================================================
   // registers
   // ================================================================
   logic               aw_full_q;
   logic [ADDR_W-1:0]  aw_addr_q;
   logic               w_full_q;
   logic [31:0]        w_data_q;
   logic [3:0]         w_strb_q;
   logic [31:0]        subsys_id_q;
   logic [29:0]        legacy_base_q;
   logic [1:0]         pwr_state_q;
   logic               wake_en_q;
   logic [31:0]        dma_setup_q;
   logic               id_lock_q;
   logic [1:0]         dma_request_line_q1, dma_request_line_q2;
   logic               wake_status, wake_req_i;

   // ================================================================
   // write path decode
   // ================================================================
   logic               wr_fire, wr_hit, wake_clear;
   logic [31:0]        wmask, wr_merge_id, wr_merge_leg, wr_merge_dma;
   logic               sel_id, sel_leg, sel_csr, sel_dma, sel_misc;
   logic [7:0]         wofs;

   // fire once both halves of the write are held and no answer pending
   assign wr_fire  = aw_full_q & w_full_q & ~s_axi_bvalid;
   assign wofs     = aw_addr_q[7:0];
   assign wmask    = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                      {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
   assign sel_id   = wr_fire & (wofs == OFS_SUBSYS_ID);
   assign sel_leg  = wr_fire & (wofs == OFS_LEGACY_BASE);
   assign sel_csr  = wr_fire & (wofs == OFS_PM_CSR);
   assign sel_dma  = wr_fire & (wofs == OFS_DMA_SETUP);
   assign sel_misc = wr_fire & (wofs == OFS_MISC_CTRL);
   assign wr_hit   = (wofs == OFS_SUBSYS_ID) | (wofs == OFS_LEGACY_BASE)
                   | (wofs == OFS_PM_CAP) | (wofs == OFS_PM_CSR)
                   | (wofs == OFS_DMA_SETUP) | (wofs == OFS_MISC_CTRL)
                   | (wofs == OFS_HW_STATUS);
   assign wr_merge_id  = (subsys_id_q & ~wmask) | (w_data_q & wmask);
   assign wr_merge_leg = ({legacy_base_q, LEGACY_IO_IND} & ~wmask)
                       | (w_data_q & wmask);
   assign wr_merge_dma = (dma_setup_q & ~wmask) | (w_data_q & wmask);
   // write one to status bit clears it
   assign wake_clear   = sel_csr & w_strb_q[1] & w_data_q[CSR_WAKE_ST_BIT];

   // ================================================================
   // axi write channel holding
   // ================================================================
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_full_q <= 1'b0;
         aw_addr_q <= '0;
         w_full_q  <= 1'b0;
         w_data_q  <= 32'h0000_0000;
         w_strb_q  <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid & s_axi_awready)
         begin
            aw_full_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         else if (wr_fire)
            aw_full_q <= 1'b0;
         if (s_axi_wvalid & s_axi_wready)
         begin
            w_full_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         else if (wr_fire)
            w_full_q <= 1'b0;
      end
   end

   // ready flags and write response
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end
      else
      begin
         s_axi_awready <= ~aw_full_q & ~(s_axi_awvalid & s_axi_awready);
         s_axi_wready  <= ~w_full_q & ~(s_axi_wvalid & s_axi_wready);
         if (wr_fire)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // ================================================================
   // configuration registers
   // ================================================================
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         subsys_id_q   <= RST_SUBSYS_ID;
         legacy_base_q <= RST_LEGACY_BASE;
         pwr_state_q   <= RST_PWR_STATE;
         wake_en_q     <= 1'b0;
         dma_setup_q   <= RST_DMA_SETUP;
         id_lock_q     <= 1'b0;
      end
      else
      begin
         if (sel_id & ~id_lock_q)
            subsys_id_q <= wr_merge_id;
         if (sel_leg)
            legacy_base_q <= wr_merge_leg[31:2];
         if (sel_csr & w_strb_q[0])
            pwr_state_q <= w_data_q[1:0];
         if (sel_csr & w_strb_q[1])
            wake_en_q <= w_data_q[CSR_WAKE_EN_BIT];
         if (sel_dma)
            dma_setup_q <= wr_merge_dma;
         if (sel_misc & w_strb_q[0])
            id_lock_q <= w_data_q[0];
      end
   end

   // ================================================================
   // wake status flag
   // ================================================================
   bpd_wake_flag u_wake
   (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .wake_event (wake_event),
      .clear_req  (wake_clear),
      .enable     (wake_en_q),
      .status_q   (wake_status),
      .wake_req_q (wake_req_i)
   );

   // request enables from a neighbouring block pass a synchroniser
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         dma_request_line_q1 <= 2'h0;
         dma_request_line_q2 <= 2'h0;
      end
      else
      begin
         dma_request_line_q1 <= dma_request_enable;
         dma_request_line_q2 <= dma_request_line_q1;
      end
   end

   // ================================================================
   // read path
   // ================================================================
   logic [31:0] rd_cap, rd_csr, rd_mux;
   logic [7:0]  rofs;
   logic        rd_hit;

   assign rofs   = s_axi_araddr[7:0];
   assign rd_cap = {PM_CAP_FLAGS, PM_REVISION, PM_NEXT_PTR, PM_CAP_ID};
   // data fields and bits 23:16 stay zero
   assign rd_csr = {16'h0000, wake_status, 6'h00, wake_en_q,
                    6'h00, pwr_state_q};
   assign rd_hit = (rofs == OFS_SUBSYS_ID) | (rofs == OFS_LEGACY_BASE)
                 | (rofs == OFS_PM_CAP) | (rofs == OFS_PM_CSR)
                 | (rofs == OFS_DMA_SETUP) | (rofs == OFS_MISC_CTRL)
                 | (rofs == OFS_HW_STATUS);
   assign rd_mux = (rofs == OFS_SUBSYS_ID)   ? subsys_id_q
                 : (rofs == OFS_LEGACY_BASE) ? {legacy_base_q, LEGACY_IO_IND}
                 : (rofs == OFS_PM_CAP)      ? rd_cap
                 : (rofs == OFS_PM_CSR)      ? rd_csr
                 : (rofs == OFS_DMA_SETUP)   ? dma_setup_q
                 : (rofs == OFS_MISC_CTRL)   ? {31'h0000_0000, id_lock_q}
                 : (rofs == OFS_HW_STATUS)   ? {29'h0000_0000, dma_request_line_q2, wake_req_i}
                 : 32'h0000_0000;

   // read answer one cycle after address acceptance
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
         if (s_axi_arvalid & s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // ================================================================
   // socket side outputs
   // ================================================================
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wake_pin_req     <= 1'b0;
         power_state      <= BPD_D0;
         legacy_decode_en <= 1'b0;
         legacy_io_base   <= RST_LEGACY_BASE;
         dma_cfg          <= '0;
      end
      else
      begin
         wake_pin_req     <= wake_req_i;
         power_state      <= bpd_pstate_t'(pwr_state_q);
         legacy_decode_en <= (legacy_base_q != 30'h0000_0000);
         legacy_io_base   <= legacy_base_q;
         dma_cfg.allowed  <= dma_setup_q[0] & (|dma_request_line_q2);
         dma_cfg.wide16   <= (dma_setup_q[2:1] != DMA_SIZE_8BIT);
         dma_cfg.ext_addr <= dma_setup_q[3];
         dma_cfg.io_base  <= dma_setup_q[31:4];
      end
   end

   // ================================================================
   // assertions
   // ================================================================
   property p_lock_holds_id;
      @(posedge aclk) disable iff (!aresetn)
      (id_lock_q && sel_id) |=> $stable(subsys_id_q);
   endproperty
   a_lock_holds_id: assert property (p_lock_holds_id)
      else $error("subsystem id changed while locked");
   property p_decode_off_zero;
      @(posedge aclk) disable iff (!aresetn)
      (legacy_base_q == 30'h0000_0000) |=> !legacy_decode_en;
   endproperty
   a_decode_off_zero: assert property (p_decode_off_zero)
      else $error("legacy decode on with zero base");
   property p_wake_gate;
      @(posedge aclk) disable iff (!aresetn)
      wake_pin_req |-> $past(wake_en_q, 2);
   endproperty
   a_wake_gate: assert property (p_wake_gate)
      else $error("wake request without enable");
   property p_dma_allowed;
      @(posedge aclk) disable iff (!aresetn)
      dma_cfg.allowed |-> ($past(dma_setup_q[0]) && ($past(dma_request_line_q2) != 2'h0));
   endproperty
   a_dma_allowed: assert property (p_dma_allowed)
      else $error("dma allowed without enables");
   property p_size_map;
      @(posedge aclk) disable iff (!aresetn)
      (dma_setup_q[2:1] == DMA_SIZE_8BIT) ##1 $stable(dma_setup_q) |-> !dma_cfg.wide16;
   endproperty
   a_size_map: assert property (p_size_map)
      else $error("8-bit size reported as 16-bit");
   property p_csr_zero;
      @(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid && $rose(s_axi_rvalid) && ($past(rofs) == OFS_PM_CSR)
      |-> (s_axi_rdata[31:16] == 16'h0000) && (s_axi_rdata[14:9] == 6'h00);
   endproperty
   a_csr_zero: assert property (p_csr_zero)
      else $error("control/status zero fields nonzero");
   property p_lock_reset;
      @(posedge aclk)
      !aresetn |=> !id_lock_q;
   endproperty
   a_lock_reset: assert property (p_lock_reset)
      else $error("lock bit not cleared by reset");

endmodule : bpd_config_regs

// ==== sim/bridge_pm_dma_config_regs_bench.sv ====
// ====================================================================
// self-checking bench for the power/dma configuration registers
// ====================================================================
module bridge_pm_dma_config_regs_bench
   import bpd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic               aclk = 1'b0;
   logic               aresetn = 1'b0;
   logic [7:0]         s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic               s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic               s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0]        s_axi_wdata = 32'h0000_0000;
   logic               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]         s_axi_bresp, s_axi_rresp;
   logic [31:0]        s_axi_rdata;
   logic               wake_event = 1'b0;
   logic [1:0]         dma_request_enable = 2'h0;
   logic               wake_pin_req, legacy_decode_en;
   logic [29:0]        legacy_io_base;
   bpd_pstate_t        power_state;
   bpd_dma_cfg_t       dma_cfg;
   int                 failures = 0;
   int                 checks = 0;
   int                 seed = 32'hACF1_2A3F;
   logic [1:0]         bq[$];
   logic [33:0]        rq[$];

   // ================================================================
   // clock and design
   // ================================================================
   always #12.5 aclk = ~aclk;

   bpd_config_regs #(.ADDR_W(8)) DUT
   (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .wake_event(wake_event),
      .dma_request_enable(dma_request_enable), .wake_pin_req(wake_pin_req),
      .power_state(power_state), .legacy_decode_en(legacy_decode_en),
      .legacy_io_base(legacy_io_base), .dma_cfg(dma_cfg)
   );

   // ================================================================
   // compare, verdict and bus tasks
   // ================================================================
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic results();
      if (failures == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : results

   // write: address and data offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      bit done;
      done = 1'b0;
      bq.push_back(r);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      while (!done)
      begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) done = 1'b1;
      end
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask : wr

   // read: expected answer noted, then address held until taken
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      bit done;
      done = 1'b0;
      rq.push_back({r, d});
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      while (!done)
      begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) done = 1'b1;
      end
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask : rd

   // let a register write reach the socket side outputs
   task automatic settle();
      repeat (4) @(posedge aclk);
   endtask : settle

   // ================================================================
   // monitor: pairs each answer with the oldest note
   // ================================================================
   always @(posedge aclk)
   begin
      logic [33:0] e;
      if (s_axi_bvalid && s_axi_bready)
         chk("bresp", 32'(bq.pop_front()), 32'(s_axi_bresp));
      if (s_axi_rvalid && s_axi_rready)
      begin
         e = rq.pop_front();
         chk("rresp", 32'(e[33:32]), 32'(s_axi_rresp));
         chk("rdata", e[31:0], s_axi_rdata);
      end
   end

   // watchdog against a hung handshake
   initial
   begin
      #(25 * 20000);
      failures++;
      results();
   end

   // ================================================================
   // main sequence
   // ================================================================
   initial
   begin
      logic [31:0] v;
      logic [31:0] r;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      // reset values and constant capability word
      rd(OFS_PM_CAP, 32'hFE11_0001, RESP_OKAY);
      wr(OFS_PM_CAP, 32'h0000_0000, RESP_OKAY);
      rd(OFS_PM_CAP, 32'hFE11_0001, RESP_OKAY);
      rd(OFS_MISC_CTRL, 32'h0000_0000, RESP_OKAY);
      rd(OFS_LEGACY_BASE, 32'h0000_0001, RESP_OKAY);
      rd(OFS_DMA_SETUP, 32'h0000_0000, RESP_OKAY);
      // unmapped place refused
      rd(8'h50, 32'h0000_0000, RESP_SLVERR);
      wr(8'h50, 32'hFFFF_FFFF, RESP_SLVERR);
      // subsystem id with lock
      v = $random(seed);
      wr(OFS_SUBSYS_ID, v, RESP_OKAY);
      rd(OFS_SUBSYS_ID, v, RESP_OKAY);
      wr(OFS_MISC_CTRL, 32'h0000_0001, RESP_OKAY);
      wr(OFS_SUBSYS_ID, ~v, RESP_OKAY);
      rd(OFS_SUBSYS_ID, v, RESP_OKAY);
      wr(OFS_MISC_CTRL, 32'h0000_0000, RESP_OKAY);
      wr(OFS_SUBSYS_ID, ~v, RESP_OKAY);
      rd(OFS_SUBSYS_ID, ~v, RESP_OKAY);
      // legacy base: all ones, zero, conventional value
      wr(OFS_LEGACY_BASE, 32'hFFFF_FFFF, RESP_OKAY);
      rd(OFS_LEGACY_BASE, 32'hFFFF_FFFD, RESP_OKAY);
      settle();
      chk("legacy_io_base", 32'h3FFF_FFFF, 32'(legacy_io_base));
      wr(OFS_LEGACY_BASE, 32'h0000_0000, RESP_OKAY);
      settle();
      chk("legacy_decode_en", 32'h0, 32'(legacy_decode_en));
      wr(OFS_LEGACY_BASE, 32'h0000_03E1, RESP_OKAY);
      settle();
      chk("legacy_decode_en", 32'h1, 32'(legacy_decode_en));
      chk("legacy_io_base", 32'h0000_00F8, 32'(legacy_io_base));
      // control/status: fixed fields and every power state
      wr(OFS_PM_CSR, 32'hFFFF_7EFF, RESP_OKAY);
      rd(OFS_PM_CSR, 32'h0000_0003, RESP_OKAY);
      for (int i = 0; i < 4; i++)
      begin
         wr(OFS_PM_CSR, 32'(i), RESP_OKAY);
         settle();
         chk("power_state", 32'(i), 32'(power_state));
      end
      // wake status sets with enable clear, pin stays quiet
      wr(OFS_PM_CSR, 32'h0000_0000, RESP_OKAY);
      wake_event <= 1'b1;
      @(posedge aclk);
      wake_event <= 1'b0;
      settle();
      chk("wake_pin_req", 32'h0, 32'(wake_pin_req));
      rd(OFS_PM_CSR, 32'h0000_8000, RESP_OKAY);
      wr(OFS_PM_CSR, 32'h0000_0100, RESP_OKAY);
      rd(OFS_PM_CSR, 32'h0000_8100, RESP_OKAY);
      settle();
      chk("wake_pin_req", 32'h1, 32'(wake_pin_req));
      wr(OFS_PM_CSR, 32'h0000_8100, RESP_OKAY);
      rd(OFS_PM_CSR, 32'h0000_0100, RESP_OKAY);
      settle();
      chk("wake_pin_req", 32'h0, 32'(wake_pin_req));
      // dma setup: every low-field code with random base and requests
      for (int i = 0; i < 16; i++)
      begin
         v = $random(seed);
         r = $random(seed);
         v[3:0] = 4'(i);
         dma_request_enable <= r[1:0];
         wr(OFS_DMA_SETUP, v, RESP_OKAY);
         rd(OFS_DMA_SETUP, v, RESP_OKAY);
         settle();
         chk("dma_cfg", {1'b0, v[0] & (|r[1:0]), v[2:1] != 2'h0, v[3], v[31:4]},
             {1'b0, dma_cfg});
      end
      results();
   end

endmodule : bridge_pm_dma_config_regs_bench
